// ---- ttwu_top.sv ----
// ttwu_top: one trigger output unit driving a waveform onto a chosen gpio.
// assumes sys_time, target_time and the other units' gpio vector come
// from logic on clk; registers are written through a 16-bit host port.
// How it works
// - edge modes drive from idle and hold
// - pulse modes give one pulse then idle
// - periodic modes: active phase, period, count
// - zero count repeats until unit stopped, except a pattern-mode cascade tail
// - pattern mode shifts 16 bits lsb first
// - pin field routes output to gpio 0-6
// - units on one pin are ORed
// - pulse width counts in 8 ns steps
// - cascade tail: pulse width plus one is iteration count
// - 32-bit cycle or bit width in ns
// - trigger now fires late targets at once
// - notify gates done and error reporting
`timescale 1ns/1ns
module ttwu_top
    import ttwu_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [DATA_W-1:0] reg_wdata,
    output logic      [DATA_W-1:0] reg_rdata,
    input  wire logic              unit_enable,
    input  wire logic              trigger_irq_enable,
    input  wire logic              status_clear,
    input  wire logic [63:0]       sys_time,
    input  wire logic [63:0]       target_time,
    input  wire logic [GPIO_N-1:0] gpio_from_others,
    output logic      [GPIO_N-1:0] gpio_out,
    output logic                   fire_complete_flag,
    output logic                   fire_error_flag,
    output logic                   trigger_irq
);

    // ==========================================================
    // register file
    ttwu_cfg_s         cfg_q;
    logic [15:0]       pw_q;
    logic [15:0]       cwl_q;
    logic [15:0]       cwh_q;
    logic [15:0]       cnt_lim_q;
    logic [15:0]       pat_q;
    logic [DATA_W-1:0] rdata_q;

    wire sel_cfg = (reg_addr == TRIGGER_CONFIG_CONTROL);
    wire sel_pw  = (reg_addr == TRIGGER_PULSE_WIDTH);
    wire sel_cwl = (reg_addr == TRIGGER_CYCLE_WIDTH_LOW);
    wire sel_cwh = (reg_addr == TRIGGER_CYCLE_WIDTH_HIGH);
    wire sel_cnt = (reg_addr == CYCLE_OR_BIT_COUNT);
    wire sel_pat = (reg_addr == OUTPUT_BIT_PATTERN);

    logic [DATA_W-1:0] rd_mux;
    always_comb begin
        if (sel_cfg) begin
            rd_mux = {cfg_q[15:8], 1'b0, cfg_q[6:0]};
        end else if (sel_pw) begin
            rd_mux = pw_q;
        end else if (sel_cwl) begin
            rd_mux = cwl_q;
        end else if (sel_cwh) begin
            rd_mux = cwh_q;
        end else if (sel_cnt) begin
            rd_mux = cnt_lim_q;
        end else if (sel_pat) begin
            rd_mux = pat_q;
        end else begin
            rd_mux = WORD_RESET;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q     <= ttwu_cfg_s'(CFG_RESET);
            pw_q      <= WORD_RESET;
            cwl_q     <= WORD_RESET;
            cwh_q     <= WORD_RESET;
            cnt_lim_q <= WORD_RESET;
            pat_q     <= WORD_RESET;
            rdata_q   <= WORD_RESET;
        end else begin
            if (reg_wr && sel_cfg) cfg_q     <= ttwu_cfg_s'(reg_wdata & ~16'h0080);
            if (reg_wr && sel_pw)  pw_q      <= reg_wdata;
            if (reg_wr && sel_cwl) cwl_q     <= reg_wdata;
            if (reg_wr && sel_cwh) cwh_q     <= reg_wdata;
            if (reg_wr && sel_cnt) cnt_lim_q <= reg_wdata;
            if (reg_wr && sel_pat) pat_q     <= reg_wdata;
            if (reg_rd)            rdata_q   <= rd_mux;
        end
    end

    // ==========================================================
    // waveform decode
    // all widths are tracked in ns so both 8 ns and 1 ns units share one counter
    wire        [31:0] pw_ns     = 32'(pw_q) * 32'(PW_UNIT_NS);
    wire        [31:0] cyc_ns    = {cwh_q, cwl_q};
    ttwu_mode_e        mode;
    assign mode = cfg_q.mode;
    wire idle_lvl  = (mode == falling_edge_mode) || (mode == low_pulse_mode)
                  || (mode == low_periodic_mode);
    wire active    = ~idle_lvl;
    wire is_edge   = (mode == falling_edge_mode) || (mode == rising_edge_mode);
    wire is_tail   = cfg_q.cascade_en && cfg_q.cascade_tail;
    wire late      = sys_time > target_time;
    wire reached   = sys_time >= target_time;

    ttwu_state_e st_q, st_d;
    logic [31:0] phase_q, phase_d;
    logic [15:0] cnt_q, cnt_d;
    logic [3:0]  bit_q, bit_d;
    logic [15:0] iter_q, iter_d;
    logic        own_q, own_d;
    logic        done_ev, err_ev;

    wire [31:0] phase_nx   = phase_q + 32'(CLK_NS);
    wire        pulse_end  = phase_nx >= pw_ns;
    wire        period_end = phase_nx >= cyc_ns;
    wire [15:0] cnt_nx     = cnt_q + 16'h0001;
    wire        lim_hit    = (cnt_lim_q != WORD_RESET) && (cnt_nx == cnt_lim_q);
    wire        loop_end   = (cnt_lim_q != WORD_RESET) ? lim_hit : (bit_q == 4'hF);

    // ==========================================================
    // sequencer
    always_comb begin
        st_d    = st_q;
        phase_d = phase_q;
        cnt_d   = cnt_q;
        bit_d   = bit_q;
        iter_d  = iter_q;
        own_d   = own_q;
        done_ev = 1'b0;
        err_ev  = 1'b0;
        case (st_q)
            ST_IDLE: begin
                own_d   = 1'b0;
                phase_d = 32'h0;
                cnt_d   = 16'h0;
                bit_d   = 4'h0;
                iter_d  = 16'h0;
                // the reserved code is left unarmed so the pin stays quiet
                if (unit_enable && mode != reserved_mode) begin
                    own_d = idle_lvl;
                    if (late && !cfg_q.trigger_now) begin
                        st_d   = ST_HOLD;
                        err_ev = 1'b1;
                    end else begin
                        st_d = ST_ARMED;
                    end
                end
            end
            ST_ARMED: begin
                own_d = idle_lvl;
                if (reached) begin
                    st_d = ST_RUN;
                end
            end
            ST_RUN: begin
                case (mode)
                    falling_edge_mode, rising_edge_mode: begin
                        own_d   = active;
                        st_d    = ST_HOLD;
                        done_ev = 1'b1;
                    end
                    low_pulse_mode, high_pulse_mode: begin
                        own_d   = active;
                        phase_d = phase_nx;
                        if (pulse_end) begin
                            st_d    = ST_HOLD;
                            done_ev = 1'b1;
                        end
                    end
                    low_periodic_mode, high_periodic_mode: begin
                        own_d   = (phase_q < pw_ns) ? active : idle_lvl;
                        phase_d = phase_nx;
                        if (period_end) begin
                            phase_d = 32'h0;
                            cnt_d   = cnt_nx;
                            if (lim_hit) begin
                                st_d    = ST_HOLD;
                                done_ev = 1'b1;
                            end
                        end
                    end
                    bit_pattern_mode: begin
                        own_d   = pat_q[bit_q];
                        phase_d = phase_nx;
                        if (period_end) begin
                            phase_d = 32'h0;
                            bit_d   = bit_q + 4'h1;
                            cnt_d   = cnt_nx;
                            if (loop_end) begin
                                cnt_d = 16'h0;
                                bit_d = 4'h0;
                                if (is_tail) begin
                                    iter_d = iter_q + 16'h0001;
                                    if (iter_q == pw_q) begin
                                        st_d    = ST_HOLD;
                                        done_ev = 1'b1;
                                    end
                                end else if (cnt_lim_q != WORD_RESET) begin
                                    st_d    = ST_HOLD;
                                    done_ev = 1'b1;
                                end
                            end
                        end
                    end
                    default: begin
                        own_d = 1'b0;
                        st_d  = ST_HOLD;
                    end
                endcase
            end
            ST_HOLD: begin
                // an edge holds only if it fired; a late-target hold stays idle
                own_d = is_edge ? own_q : idle_lvl;
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
        // dropping the enable stops any run, including unlimited repeats
        if (!unit_enable) begin
            st_d  = ST_IDLE;
            own_d = 1'b0;
        end
    end

    // ==========================================================
    // pin routing and status
    logic [GPIO_N-1:0] own_vec;
    always_comb begin
        own_vec = '0;
        // codes above the last pin drive nothing
        if (cfg_q.pin_sel <= PIN_MAX) begin
            own_vec[cfg_q.pin_sel[2:0]] = own_q;
        end
    end

    logic [GPIO_N-1:0] gpio_q;
    logic              done_q;
    logic              err_q;
    logic              irq_q;
    // set wins over a clear arriving in the same cycle
    wire done_d = (done_ev && cfg_q.notify) || (done_q && !status_clear);
    wire err_d  = (err_ev && cfg_q.notify) || (err_q && !status_clear);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q    <= ST_IDLE;
            phase_q <= 32'h0;
            cnt_q   <= 16'h0;
            bit_q   <= 4'h0;
            iter_q  <= 16'h0;
            own_q   <= 1'b0;
            gpio_q  <= '0;
            done_q  <= 1'b0;
            err_q   <= 1'b0;
            irq_q   <= 1'b0;
        end else begin
            st_q    <= st_d;
            phase_q <= phase_d;
            cnt_q   <= cnt_d;
            bit_q   <= bit_d;
            iter_q  <= iter_d;
            own_q   <= own_d;
            gpio_q  <= gpio_from_others | own_vec;
            done_q  <= done_d;
            err_q   <= err_d;
            irq_q   <= trigger_irq_enable && (done_d || err_d);
        end
    end

    assign reg_rdata          = rdata_q;
    assign gpio_out           = gpio_q;
    assign fire_complete_flag = done_q;
    assign fire_error_flag    = err_q;
    assign trigger_irq        = irq_q;

endmodule // ttwu_top

// ---- ttwu_pkg.sv ----
// ttwu_pkg: constants, register map and types of one trigger output unit.
// assumes a 250 MHz precision system clock and a 16-bit host register port.
package ttwu_pkg;

    // ==========================================================
    // timing
    localparam int CLK_MHZ      = 250;
    localparam int CLK_NS       = 1000 / CLK_MHZ;
    localparam int PW_UNIT_NS   = 8;

    // ==========================================================
    // register map, byte addresses of 16-bit registers
    localparam int          ADDR_W                    = 12;
    localparam int          DATA_W                    = 16;
    localparam int          PAT_BITS                  = 16;
    localparam int          GPIO_N                    = 7;
    localparam logic [11:0] TRIGGER_CONFIG_CONTROL    = 12'h228;
    localparam logic [11:0] TRIGGER_PULSE_WIDTH       = 12'h22A;
    localparam logic [11:0] TRIGGER_CYCLE_WIDTH_LOW   = 12'h22C;
    localparam logic [11:0] TRIGGER_CYCLE_WIDTH_HIGH  = 12'h22E;
    localparam logic [11:0] CYCLE_OR_BIT_COUNT        = 12'h230;
    localparam logic [11:0] OUTPUT_BIT_PATTERN        = 12'h232;

    // ==========================================================
    // reset values and the last pin code
    localparam logic [15:0] CFG_RESET   = 16'h3C00;
    localparam logic [15:0] WORD_RESET  = 16'h0000;
    localparam logic [3:0]  PIN_MAX     = 4'h6;

    // ==========================================================
    // types
    typedef enum logic [2:0] {
        falling_edge_mode   = 3'h0,
        rising_edge_mode    = 3'h1,
        low_pulse_mode      = 3'h2,
        high_pulse_mode     = 3'h3,
        low_periodic_mode   = 3'h4,
        high_periodic_mode  = 3'h5,
        bit_pattern_mode    = 3'h6,
        reserved_mode       = 3'h7
    } ttwu_mode_e;

    typedef struct packed {
        logic       cascade_en;
        logic       cascade_tail;
        logic [3:0] upstream_sel;
        logic       trigger_now;
        logic       notify;
        logic       rsvd;
        ttwu_mode_e mode;
        logic [3:0] pin_sel;
    } ttwu_cfg_s;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ARMED = 2'b01,
        ST_RUN   = 2'b11,
        ST_HOLD  = 2'b10
    } ttwu_state_e;

endpackage

// ---- ttwu_asserts.sv ----
// ttwu_asserts: port-level checks of one trigger output unit.
// assumes one clk domain; bound into every ttwu_top below.
`timescale 1ns/1ns
module ttwu_asserts
    import ttwu_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic              unit_enable,
    input wire logic              trigger_irq_enable,
    input wire logic              status_clear,
    input wire logic [63:0]       sys_time,
    input wire logic [63:0]       target_time,
    input wire logic [GPIO_N-1:0] gpio_from_others,
    input wire logic [GPIO_N-1:0] gpio_out,
    input wire logic              fire_complete_flag,
    input wire logic              fire_error_flag,
    input wire logic              trigger_irq
);
    // ==========
    // shadows of host writes and a count of own-pin high cycles
    logic [15:0]       cfg_q;
    logic [15:0]       pw_q;
    logic [15:0]       hi_q;
    logic [GPIO_N-1:0] mask;
    logic              pbit;
    // pin codes 7..F route nothing
    assign mask = (cfg_q[3:0] <= PIN_MAX) ? (7'h01 << cfg_q[3:0]) : 7'h00;
    assign pbit = |(gpio_out & mask);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= CFG_RESET;
            pw_q  <= WORD_RESET;
            hi_q  <= 16'h0000;
        end else begin
            if (reg_wr && reg_addr == TRIGGER_CONFIG_CONTROL) cfg_q <= reg_wdata;
            if (reg_wr && reg_addr == TRIGGER_PULSE_WIDTH) pw_q <= reg_wdata;
            hi_q <= pbit ? hi_q + 16'h0001 : 16'h0000;
        end
    end
    // ==========
    // properties
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_pw_readback: assert property (
        reg_rd && reg_addr == TRIGGER_PULSE_WIDTH ##1 !(reg_rd || reg_wr)
        |=> reg_rdata == pw_q) else $error("pulse width readback wrong");
    a_route_mask: assert property ($stable(cfg_q) |->
        ((gpio_out ^ $past(gpio_from_others)) & ~mask) == 7'h00)
        else $error("output reached an unselected pin");
    a_or_others: assert property (
        ($past(gpio_from_others) & ~gpio_out) == 7'h00) else $error("pins not ORed");
    a_edge_hold: assert property (
        cfg_q[6:4] == 3'h1 && unit_enable && $past(unit_enable) && pbit
        && !(|($past(gpio_from_others) & mask)) |=> pbit) else $error("edge not held");
    a_pulse_len: assert property (
        cfg_q[6:4] == 3'h3 && $fell(pbit) && $past(unit_enable, 2)
        |-> hi_q == ((pw_q == 16'h0000) ? 16'h0001 : pw_q << 1))
        else $error("pulse length wrong");
    a_notify_gate: assert property (
        $rose(fire_complete_flag) || $rose(fire_error_flag) |-> cfg_q[8])
        else $error("status without notify");
    a_flag_sticky: assert property (
        fire_complete_flag && !status_clear |=> fire_complete_flag)
        else $error("done flag lost");
    a_irq_gate: assert property (
        !$past(trigger_irq_enable) |-> !trigger_irq) else $error("irq while masked");
    c_pulse: cover property (cfg_q[6:4] == 3'h3 && $fell(pbit));
    c_done: cover property ($rose(fire_complete_flag));
    c_err: cover property ($rose(fire_error_flag));
endmodule // ttwu_asserts
bind ttwu_top ttwu_asserts ttwu_asserts_i (.clk, .rst_n, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .unit_enable, .trigger_irq_enable, .status_clear, .sys_time,
    .target_time, .gpio_from_others, .gpio_out, .fire_complete_flag, .fire_error_flag,
    .trigger_irq);

// ---- ttwu_pins_model.sv ----
// ttwu_pins_model: the other trigger units sharing the gpio pins.
// assumes the bench asks for their levels through others_req.
`timescale 1ns/1ns
module ttwu_pins_model
    import ttwu_pkg::*;
(
    input  wire logic              clk,
    input  wire logic [GPIO_N-1:0] others_req,
    output logic      [GPIO_N-1:0] gpio_from_others
);
    // other units register on clk like this one
    always_ff @(posedge clk) begin
        gpio_from_others <= others_req;
    end
endmodule // ttwu_pins_model

// ---- tb_top.sv ----
// tb_top: self-checking bench of one trigger output unit.
// assumes ttwu_top, ttwu_pins_model and the bound checker.
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end
module tb_top
    import ttwu_pkg::*;
();
    logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, unit_enable = 1'b0;
    logic trigger_irq_enable = 1'b0, status_clear = 1'b0, casc, nt;
    logic fire_complete_flag, fire_error_flag, trigger_irq;
    logic [11:0] reg_addr = 12'h000;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, pat;
    logic [63:0] sys_time = 64'h0, target_time = 64'h0;
    logic [6:0]  others_req = 7'h00, gpio_from_others, gpio_out;
    int          error_cnt = 0, checked = 0, cyc_cnt = 0, m, pw, cyc, cnt, lim, pin, p, fin;
    integer      seed = 72248;
    ttwu_top ttwu_top_i (.clk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .unit_enable, .trigger_irq_enable, .status_clear, .sys_time, .target_time,
        .gpio_from_others, .gpio_out, .fire_complete_flag, .fire_error_flag, .trigger_irq);
    ttwu_pins_model ttwu_pins_model_i (.clk, .others_req, .gpio_from_others);
    always #2 clk = ~clk;
    always @(posedge clk) begin
        cyc_cnt++;
        if (cyc_cnt == 30000) begin
            error_cnt++;
            finish_test();
        end
    end
    // ==========
    // host port and expectations
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(negedge clk);
        reg_addr = a; reg_wdata = d; reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [15:0] e);
        @(negedge clk);
        reg_addr = a; reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        @(negedge clk);
        `CHK(reg_rdata, e)
    endtask
    // own pin level j cycles after the first active output cycle
    function automatic logic eb(input int j);
        logic idl;
        idl = (m == 0 || m == 2 || m == 4);
        if (m == 7) return 1'b0;
        if (j < 0) return idl;
        case (m)
            0: return 1'b0;
            1: return 1'b1;
            2, 3: return (j < 2 * pw) ? m[0] : idl;
            4, 5: return (cnt != 0 && j / p >= cnt) ? idl : ((j % p < 2 * pw) ? m[0] : idl);
            default: return (lim != 0 && j / p >= lim) ? 1'b0
                : pat[(casc && cnt != 0) ? (j / p) % cnt : (j / p) % 16];
        endcase
    endfunction
    task automatic run();
        @(negedge clk);
        pin = {$random(seed)} % 7;
        casc = $random(seed);
        nt = $random(seed);
        trigger_irq_enable = $random(seed);
        pw = (m == 6) ? {$random(seed)} % 2 : 5 + {$random(seed)} % 2;
        cyc = (m == 6) ? 40 + {$random(seed)} % 9 : 80 + {$random(seed)} % 17;
        cnt = {$random(seed)} % 3;
        pat = $random(seed);
        p = (cyc + 3) / 4;
        lim = casc ? ((cnt == 0) ? 16 : cnt) * (pw + 1) : cnt;
        // edge modes finish at the fire edge, so they report done too
        fin = (m < 2) ? 1 : (m == 2 || m == 3) ? 2 * pw
            : (m == 4 || m == 5) ? cnt * p : (m == 6) ? lim * p : 0;
        // code 7 written on purpose: output must stay quiet
        wr(TRIGGER_CONFIG_CONTROL, {casc, casc, 4'hF, 1'b0, nt, 1'b0, 3'(m), 4'(pin)});
        wr(TRIGGER_PULSE_WIDTH, 16'(pw));
        wr(TRIGGER_CYCLE_WIDTH_LOW, 16'(cyc));
        wr(TRIGGER_CYCLE_WIDTH_HIGH, 16'h0000);
        wr(CYCLE_OR_BIT_COUNT, 16'(cnt));
        wr(OUTPUT_BIT_PATTERN, pat);
        sys_time = 64'h0;
        target_time = 64'h3E8;
        unit_enable = 1'b1;
        repeat (3) @(negedge clk);
        sys_time = 64'h3E8;
        for (int k = 1; k <= 64; k++) begin
            @(negedge clk);
            if (k == 60) others_req[pin] = 1'b1;
            `CHK(gpio_out[pin], eb(k - 3) | (k >= 62))
        end
        `CHK(fire_complete_flag, nt && fin > 0 && fin <= 56)
        `CHK(trigger_irq, trigger_irq_enable && nt && fin > 0 && fin <= 56)
        others_req = 7'h00;
        unit_enable = 1'b0;
        status_clear = 1'b1;
        @(negedge clk);
        status_clear = 1'b0;
        @(negedge clk);
        `CHK(fire_complete_flag, 1'b0)
    endtask
    task automatic finish_test();
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ==========
    // main sequence
    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        for (int i = 0; i < 6; i++) rd(12'h228 + 12'(2 * i), (i == 0) ? CFG_RESET : WORD_RESET);
        wr(12'h234, 16'hFFFF);
        rd(12'h234, 16'h0000);
        wr(TRIGGER_CONFIG_CONTROL, 16'hFFFF);
        rd(TRIGGER_CONFIG_CONTROL, 16'hFF7F);
        for (int i = 1; i < 6; i++) begin
            pat = $random(seed);
            wr(12'h228 + 12'(2 * i), pat);
            rd(12'h228 + 12'(2 * i), pat);
        end
        for (int r = 0; r < 24; r++) begin
            m = r % 8;
            run();
        end
        for (int t = 0; t < 2; t++) begin
            wr(TRIGGER_CONFIG_CONTROL, {6'h0F, 1'(t), 1'b1, 1'b0, 3'h1, 4'h0});
            sys_time = 64'h7D0;
            target_time = 64'h3E8;
            unit_enable = 1'b1;
            repeat (6) @(negedge clk);
            `CHK(gpio_out[0], 1'(t))
            `CHK(fire_error_flag, 1'(1 - t))
            unit_enable = 1'b0;
            status_clear = 1'b1;
            @(negedge clk);
            status_clear = 1'b0;
        end
        finish_test();
    end
endmodule // tb_top
